// ==== rscfg_checker.sv ====
// port assertions for the stream, gain and clock configuration block
// ==========================================================
// checker
module rscfg_checker #(
	parameter int TIME_SYNC_CYCLES = 16
) (
	// clock and reset
	input wire logic        CLK_IN,
	input wire logic        RESET_N_IN,
	// register read path
	input wire logic [7:0]  ARADDR_IN,
	input wire logic        ARVALID_IN,
	input wire logic        ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [1:0]  RRESP_OUT,
	input wire logic        RVALID_OUT,
	// register write data path
	input wire logic [31:0] WDATA_IN,
	input wire logic        WVALID_IN,
	input wire logic        WREADY_OUT,
	// stream outputs
	input wire logic [3:0]  SAMPLE_BYPASS_OUT,
	input wire logic [3:0]  STREAM_DATA_OUT,
	input wire logic        STREAM_CLK_OUT,
	input wire logic        WORD_PULSE_OUT,
	input wire logic        FRAME_SYNC_OUT,
	input wire logic        TIME_SYNC_OUT,
	// control levels
	input wire logic        INPHASE_GAIN_ON_OUT,
	input wire logic        QUAD_GAIN_ON_OUT,
	input wire logic        STREAM_INSERT_OUT,
	input wire logic [2:0]  CLOCK_OUT_DIVIDER_OUT,
	input wire logic        OSC_BAND_SELECT_OUT,
	input wire logic        CLOCK_OUT_BUFFER_ON_OUT
);
	logic [7:0]  rda_q, rda_d;
	logic [15:0] gap_q, gap_d;
	logic [3:0]  hold_q, hold_d;

	// last read address and cycles since a time pulse
	// a written counter clear restarts the time base, so no spacing is judged across it
	always_comb begin
		rda_d = rda_q;
		gap_d = gap_q;
		hold_d = (hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0;
		if (ARVALID_IN && ARREADY_OUT) rda_d = ARADDR_IN;
		if (WVALID_IN && WREADY_OUT && WDATA_IN[0]) hold_d = 4'h8;
		if (hold_q != 4'h0) gap_d = 16'h0000;
		else if (TIME_SYNC_OUT) gap_d = 16'h0001;
		else if (gap_q != 16'h0000 && gap_q != 16'hFFFF) gap_d = gap_q + 16'h0001;
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rda_q <= 8'h00;
			gap_q <= 16'h0000;
			hold_q <= 4'h0;
		end else begin
			rda_q <= rda_d;
			gap_q <= gap_d;
			hold_q <= hold_d;
		end
	end

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	a_gain_levels: assert property ($rose(RVALID_OUT) && rda_q == 8'h08 |->
		{INPHASE_GAIN_ON_OUT, QUAD_GAIN_ON_OUT, STREAM_INSERT_OUT} == RDATA_OUT[13:11])
		else $error("gain levels differ from stored word");
	a_clock_levels: assert property ($rose(RVALID_OUT) && rda_q == 8'h0C |->
		{CLOCK_OUT_DIVIDER_OUT, OSC_BAND_SELECT_OUT} == RDATA_OUT[31:28]
		&& CLOCK_OUT_BUFFER_ON_OUT == RDATA_OUT[24])
		else $error("clock levels differ from stored word");
	a_refuse_read: assert property ($rose(RVALID_OUT) && !(rda_q inside {8'h08, 8'h0C, 8'h20})
		|-> RRESP_OUT == rscfg_pkg::RESP_SLVERR && RDATA_OUT == 32'h0)
		else $error("unmapped read not refused");
	a_read_turn: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("read answer late");
	a_bypass_off: assert property (STREAM_INSERT_OUT && $past(STREAM_INSERT_OUT) |->
		SAMPLE_BYPASS_OUT == 4'h0) else $error("bypass active while inserted");
	a_idle_clock: assert property (!STREAM_INSERT_OUT && !$past(STREAM_INSERT_OUT)
		&& !$past(STREAM_INSERT_OUT, 2) |-> !STREAM_CLK_OUT) else $error("clock while bypassed");
	a_clk_pulse: assert property ($rose(STREAM_CLK_OUT) |=> !STREAM_CLK_OUT)
		else $error("stream clock high too long");
	a_data_steady: assert property (STREAM_CLK_OUT |-> $stable(STREAM_DATA_OUT))
		else $error("stream data moved while clock high");
	a_word_single: assert property (WORD_PULSE_OUT |=> (!WORD_PULSE_OUT) [*8])
		else $error("word pulse too wide");
	a_frame_start: assert property (FRAME_SYNC_OUT |-> !STREAM_CLK_OUT)
		else $error("frame sync off word start");
	a_time_insert: assert property (TIME_SYNC_OUT |->
		STREAM_INSERT_OUT || $past(STREAM_INSERT_OUT)) else $error("time pulse while bypassed");
	a_time_gap: assert property (TIME_SYNC_OUT && gap_q != 16'h0000 |->
		gap_q >= 16'(TIME_SYNC_CYCLES)) else $error("time pulses too close");
endmodule : rscfg_checker

bind rscfg_top rscfg_checker #(.TIME_SYNC_CYCLES(TIME_SYNC_CYCLES)) checker_u (.CLK_IN,
	.RESET_N_IN, .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT,
	.WDATA_IN, .WVALID_IN, .WREADY_OUT,
	.SAMPLE_BYPASS_OUT, .STREAM_DATA_OUT, .STREAM_CLK_OUT, .WORD_PULSE_OUT, .FRAME_SYNC_OUT,
	.TIME_SYNC_OUT, .INPHASE_GAIN_ON_OUT, .QUAD_GAIN_ON_OUT, .STREAM_INSERT_OUT,
	.CLOCK_OUT_DIVIDER_OUT, .OSC_BAND_SELECT_OUT, .CLOCK_OUT_BUFFER_ON_OUT);

// ==== rscfg_pkg.sv ====
// constants for the stream, gain and clock configuration block
package rscfg_pkg;

	// ==========================================================
	// register indices and byte addresses
	localparam logic [3:0]  IDX_STREAM_GAIN   = 4'h2;
	localparam logic [3:0]  IDX_SYNTH_CLOCK   = 4'h3;
	localparam logic [3:0]  IDX_STATUS        = 4'h8;
	localparam logic [7:0]  ADDR_STREAM_GAIN  = {2'h0, IDX_STREAM_GAIN, 2'h0};
	localparam logic [7:0]  ADDR_SYNTH_CLOCK  = {2'h0, IDX_SYNTH_CLOCK, 2'h0};
	localparam logic [7:0]  ADDR_STATUS       = {2'h0, IDX_STATUS, 2'h0};

	// ==========================================================
	// reset values
	localparam logic [31:0] RST_STREAM_GAIN   = 32'h0EAFA1DC;
	localparam logic [31:0] RST_SYNTH_CLOCK   = 32'h698C0000;

	// ==========================================================
	// field positions of the stream and gain word
	localparam int          POS_INPHASE_GAIN  = 13;
	localparam int          POS_QUAD_GAIN     = 12;
	localparam int          POS_INSERT        = 11;
	localparam int          POS_BEGIN         = 10;
	localparam int          POS_END           = 9;
	localparam int          POS_BITSEL        = 4;
	localparam int          POS_FRAME_NUM     = 3;
	localparam int          POS_TIME_ALWAYS   = 2;
	localparam int          POS_WORD_PULSE    = 1;
	localparam int          POS_CNT_CLEAR     = 0;

	// ==========================================================
	// field positions of the synthesizer word
	localparam int          POS_DIVIDER       = 29;
	localparam int          POS_BAND          = 28;
	localparam int          POS_BUFFER_ON     = 24;

	// ==========================================================
	// codes and sizes
	localparam logic [1:0]  BITSEL_I          = 2'h1;
	localparam logic [1:0]  BITSEL_IQ         = 2'h3;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	localparam int          WORD_BITS         = 16;
	localparam int          LANES             = 4;

endpackage : rscfg_pkg

// ==== rscfg_sink.sv ====
// baseband receiver model that tallies the streamed words and pulses
module rscfg_sink (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// stream pins
	input  wire logic        stream_clk_in,
	input  wire logic [3:0]  data_in,
	input  wire logic        word_pulse_in,
	input  wire logic        frame_sync_in,
	input  wire logic        time_sync_in,
	// tallies
	output logic [15:0]      bits_out,
	output logic [15:0]      words_out,
	output logic [15:0]      pulses_out,
	output logic [15:0]      frames_out,
	output logic [15:0]      times_out,
	output logic [63:0]      word_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        sclk_q;
	logic [3:0]  cnt_q;
	logic [63:0] sh_q;

	// bits taken on each rise of the stream clock, lane 3 in the top slice
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{sclk_q, cnt_q, sh_q, word_out} <= '0;
			{bits_out, words_out, pulses_out, frames_out, times_out} <= '0;
		end else begin
			sclk_q <= stream_clk_in;
			if (frame_sync_in) frames_out <= frames_out + 16'h1;
			if (time_sync_in) times_out <= times_out + 16'h1;
			if (word_pulse_in) begin
				cnt_q <= 4'h0;
				pulses_out <= pulses_out + 16'h1;
			end else if (stream_clk_in && !sclk_q) begin
				cnt_q <= cnt_q + 4'h1;
				bits_out <= bits_out + 16'h1;
				for (int l = 0; l < 4; l++) begin
					sh_q[16*l +: 16] <= {sh_q[16*l +: 15], data_in[l]};
					if (cnt_q == 4'hF) word_out[16*l +: 16] <= {sh_q[16*l +: 15], data_in[l]};
				end
				if (cnt_q == 4'hF) words_out <= words_out + 16'h1;
			end
		end
	end
endmodule : rscfg_sink

// ==== rscfg_top.sv ====
// stream, gain and clock configuration block with its AXI4-Lite slave
module rscfg_top #(
	parameter int FRAME_WORDS      = 16,
	parameter int TIME_SYNC_CYCLES = 1024
) (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	// axi4-lite write channels
	input  wire logic [7:0]  AWADDR_IN,
	input  wire logic        AWVALID_IN,
	output logic             AWREADY_OUT,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic [3:0]  WSTRB_IN,
	input  wire logic        WVALID_IN,
	output logic             WREADY_OUT,
	output logic [1:0]       BRESP_OUT,
	output logic             BVALID_OUT,
	input  wire logic        BREADY_IN,
	// axi4-lite read channels
	input  wire logic [7:0]  ARADDR_IN,
	input  wire logic        ARVALID_IN,
	output logic             ARREADY_OUT,
	output logic [31:0]      RDATA_OUT,
	output logic [1:0]       RRESP_OUT,
	output logic             RVALID_OUT,
	input  wire logic        RREADY_IN,
	// sample pins: i msb, i lsb, q msb, q lsb
	input  wire logic [3:0]  SAMPLE_IN,
	// stream outputs
	output logic [3:0]       SAMPLE_BYPASS_OUT,
	output logic [3:0]       STREAM_DATA_OUT,
	output logic             STREAM_CLK_OUT,
	output logic             WORD_PULSE_OUT,
	output logic             FRAME_SYNC_OUT,
	output logic             TIME_SYNC_OUT,
	// analog and clock controls
	output logic             INPHASE_GAIN_ON_OUT,
	output logic             QUAD_GAIN_ON_OUT,
	output logic             STREAM_INSERT_OUT,
	output logic [2:0]       CLOCK_OUT_DIVIDER_OUT,
	output logic             OSC_BAND_SELECT_OUT,
	output logic             CLOCK_OUT_BUFFER_ON_OUT
);

	localparam int BW = rscfg_pkg::WORD_BITS;
	localparam int DW = rscfg_pkg::WORD_BITS * rscfg_pkg::LANES;

	typedef enum logic {RSCFG_SER_IDLE, RSCFG_SER_SHIFT} rscfg_ser_t;

	function automatic logic [31:0] rscfg_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : rscfg_merge

	function automatic logic [3:0] rscfg_lanes(input logic [1:0] sel);
		return (sel == rscfg_pkg::BITSEL_IQ) ? 4'hF : 4'hC;
	endfunction : rscfg_lanes

	// ==========================================================
	// bus slave and registers
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] gain_q, gain_d, synth_q, synth_d;
	logic        cmd_start_q, cmd_start_d, cmd_stop_q, cmd_stop_d;
	logic        cmd_clear_q, cmd_clear_d;
	logic        active_q;
	logic [1:0]  buf_cnt_q;
	logic [15:0] frame_num_q;

	always_comb begin
		logic [31:0] merged;
		merged      = gain_q;
		awready_d   = awready_q;
		wready_d    = wready_q;
		aw_full_d   = aw_full_q;
		w_full_d    = w_full_q;
		awaddr_d    = awaddr_q;
		wdata_d     = wdata_q;
		wstrb_d     = wstrb_q;
		bvalid_d    = bvalid_q;
		bresp_d     = bresp_q;
		arready_d   = arready_q;
		rvalid_d    = rvalid_q;
		rresp_d     = rresp_q;
		rdata_d     = rdata_q;
		gain_d      = gain_q;
		synth_d     = synth_q;
		cmd_start_d = 1'b0;
		cmd_stop_d  = 1'b0;
		cmd_clear_d = 1'b0;
		if (AWVALID_IN && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d  = AWADDR_IN;
		end
		if (WVALID_IN && wready_q) begin
			w_full_d = 1'b1;
			wdata_d  = WDATA_IN;
			wstrb_d  = WSTRB_IN;
		end
		if (bvalid_q && BREADY_IN) begin
			bvalid_d = 1'b0;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = rscfg_pkg::RESP_OKAY;
			case (awaddr_q)
				rscfg_pkg::ADDR_STREAM_GAIN: begin
					merged      = rscfg_merge(gain_q, wdata_q, wstrb_q);
					gain_d      = merged;
					cmd_start_d = merged[rscfg_pkg::POS_BEGIN] && !gain_q[rscfg_pkg::POS_BEGIN];
					cmd_stop_d  = merged[rscfg_pkg::POS_END] && !gain_q[rscfg_pkg::POS_END];
					cmd_clear_d = merged[rscfg_pkg::POS_CNT_CLEAR];
				end
				rscfg_pkg::ADDR_SYNTH_CLOCK: begin
					synth_d = rscfg_merge(synth_q, wdata_q, wstrb_q);
				end
				rscfg_pkg::ADDR_STATUS: begin
					bresp_d = rscfg_pkg::RESP_OKAY;
				end
				default: begin
					bresp_d = rscfg_pkg::RESP_SLVERR;
				end
			endcase
		end
		awready_d = !aw_full_d;
		wready_d  = !w_full_d;
		if (rvalid_q && RREADY_IN) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (!rvalid_q && !arready_q) begin
			arready_d = 1'b1;
		end
		if (ARVALID_IN && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = rscfg_pkg::RESP_OKAY;
			case (ARADDR_IN)
				rscfg_pkg::ADDR_STREAM_GAIN: rdata_d = gain_q;
				rscfg_pkg::ADDR_SYNTH_CLOCK: rdata_d = synth_q;
				rscfg_pkg::ADDR_STATUS:      rdata_d = {frame_num_q, 12'h000, buf_cnt_q,
					STREAM_INSERT_OUT, active_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = rscfg_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			awready_q   <= 1'b1;
			wready_q    <= 1'b1;
			aw_full_q   <= 1'b0;
			w_full_q    <= 1'b0;
			awaddr_q    <= 8'h00;
			wdata_q     <= 32'h00000000;
			wstrb_q     <= 4'h0;
			bvalid_q    <= 1'b0;
			bresp_q     <= 2'h0;
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b0;
			rresp_q     <= 2'h0;
			rdata_q     <= 32'h00000000;
			gain_q      <= rscfg_pkg::RST_STREAM_GAIN;
			synth_q     <= rscfg_pkg::RST_SYNTH_CLOCK;
			cmd_start_q <= 1'b0;
			cmd_stop_q  <= 1'b0;
			cmd_clear_q <= 1'b0;
		end else begin
			awready_q   <= awready_d;
			wready_q    <= wready_d;
			aw_full_q   <= aw_full_d;
			w_full_q    <= w_full_d;
			awaddr_q    <= awaddr_d;
			wdata_q     <= wdata_d;
			wstrb_q     <= wstrb_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			arready_q   <= arready_d;
			rvalid_q    <= rvalid_d;
			rresp_q     <= rresp_d;
			rdata_q     <= rdata_d;
			gain_q      <= gain_d;
			synth_q     <= synth_d;
			cmd_start_q <= cmd_start_d;
			cmd_stop_q  <= cmd_stop_d;
			cmd_clear_q <= cmd_clear_d;
		end
	end

	assign AWREADY_OUT = awready_q;
	assign WREADY_OUT  = wready_q;
	assign BVALID_OUT  = bvalid_q;
	assign BRESP_OUT   = bresp_q;
	assign ARREADY_OUT = arready_q;
	assign RVALID_OUT  = rvalid_q;
	assign RRESP_OUT   = rresp_q;
	assign RDATA_OUT   = rdata_q;
	assign INPHASE_GAIN_ON_OUT     = gain_q[rscfg_pkg::POS_INPHASE_GAIN];
	assign QUAD_GAIN_ON_OUT        = gain_q[rscfg_pkg::POS_QUAD_GAIN];
	assign STREAM_INSERT_OUT       = gain_q[rscfg_pkg::POS_INSERT];
	assign CLOCK_OUT_DIVIDER_OUT   = synth_q[rscfg_pkg::POS_DIVIDER +: 3];
	assign OSC_BAND_SELECT_OUT     = synth_q[rscfg_pkg::POS_BAND];
	assign CLOCK_OUT_BUFFER_ON_OUT = synth_q[rscfg_pkg::POS_BUFFER_ON];

	// ==========================================================
	// sample capture, collector, two-entry buffer, serialiser
	logic [3:0]    s1_q, s2_q, s3_q, filt_q, filt_d, bypass_q, bypass_d;
	logic          tick_q, tick_d, coll_valid_q, coll_valid_d;
	logic [3:0]    coll_cnt_q, coll_cnt_d;
	logic [DW-1:0] coll_word_q, coll_word_d;
	logic [DW-1:0] buf_mem_q [2];
	logic [DW-1:0] buf_mem_d [2];
	logic          buf_wp_q, buf_wp_d, buf_rp_q, buf_rp_d;
	logic [1:0]    buf_cnt_d;
	logic          active_d;
	rscfg_ser_t    ser_q, ser_d;
	logic [DW-1:0] sh_q, sh_d;
	logic [3:0]    bit_q, bit_d, data_q, data_d;
	logic          phase_q, phase_d, clk_q, clk_d;
	logic [15:0]   word_idx_q, word_idx_d, frame_num_d;
	logic          wpulse_q, wpulse_d, fsync_q, fsync_d, tsync_q, tsync_d;
	logic [31:0]   tbase_q, tbase_d;

	always_comb begin
		logic          ins, run, buf_ready, push, pop;
		logic [3:0]    mask;
		logic [DW-1:0] load;
		ins         = gain_q[rscfg_pkg::POS_INSERT];
		run         = active_q && ins;
		mask        = rscfg_lanes(gain_q[rscfg_pkg::POS_BITSEL +: 2]);
		load        = '0;
		pop         = 1'b0;
		buf_ready   = (buf_cnt_q != 2'h2);
		push        = coll_valid_q && buf_ready;
		filt_d      = (s2_q == s3_q) ? s3_q : filt_q;
		bypass_d    = ins ? 4'h0 : filt_q;
		active_d    = active_q;
		if (cmd_start_q) begin
			active_d = 1'b1;
		end
		if (cmd_stop_q) begin
			active_d = 1'b0;
		end
		tick_d       = ins && !tick_q;
		coll_valid_d = coll_valid_q && !push;
		coll_cnt_d   = coll_cnt_q;
		coll_word_d  = coll_word_q;
		if (ins && tick_q && !coll_valid_q) begin
			for (int l = 0; l < rscfg_pkg::LANES; l++) begin
				coll_word_d[l*BW +: BW] = {coll_word_q[l*BW +: BW-1], filt_q[l]};
			end
			coll_cnt_d = coll_cnt_q + 4'h1;
			if (coll_cnt_q == 4'hF) begin
				coll_valid_d = 1'b1;
			end
		end
		ser_d       = ser_q;
		sh_d        = sh_q;
		bit_d       = bit_q;
		data_d      = data_q;
		phase_d     = phase_q;
		clk_d       = 1'b0;
		word_idx_d  = word_idx_q;
		frame_num_d = frame_num_q;
		wpulse_d    = 1'b0;
		fsync_d     = 1'b0;
		case (ser_q)
			RSCFG_SER_IDLE: begin
				data_d = 4'h0;
				if (run && gain_q[rscfg_pkg::POS_FRAME_NUM] && word_idx_q == 16'h0000) begin
					load = {rscfg_pkg::LANES{frame_num_q}};
					ser_d = RSCFG_SER_SHIFT;
				end else if (run && buf_cnt_q != 2'h0) begin
					load  = buf_mem_q[buf_rp_q];
					pop   = 1'b1;
					ser_d = RSCFG_SER_SHIFT;
				end
				if (ser_d == RSCFG_SER_SHIFT) begin
					sh_d     = load;
					bit_d    = 4'h0;
					phase_d  = 1'b0;
					wpulse_d = gain_q[rscfg_pkg::POS_WORD_PULSE];
					fsync_d  = (word_idx_q == 16'h0000);
					for (int l = 0; l < rscfg_pkg::LANES; l++) begin
						data_d[l] = load[l*BW + BW-1] && mask[l];
					end
				end
			end
			RSCFG_SER_SHIFT: begin
				phase_d = !phase_q;
				clk_d   = !phase_q;
				if (phase_q) begin
					for (int l = 0; l < rscfg_pkg::LANES; l++) begin
						sh_d[l*BW +: BW] = {sh_q[l*BW +: BW-1], 1'b0};
						data_d[l]        = sh_q[l*BW + BW-2] && mask[l];
					end
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'hF) begin
						ser_d      = RSCFG_SER_IDLE;
						word_idx_d = word_idx_q + 16'h0001;
						if (word_idx_q == 16'(FRAME_WORDS - 1)) begin
							word_idx_d  = 16'h0000;
							frame_num_d = frame_num_q + 16'h0001;
						end
					end
				end
				if (!run) begin
					ser_d  = RSCFG_SER_IDLE;
					clk_d  = 1'b0;
					data_d = 4'h0;
				end
			end
			default: begin
				ser_d = RSCFG_SER_IDLE;
			end
		endcase
		buf_cnt_d   = buf_cnt_q + {1'b0, push} - {1'b0, pop};
		buf_wp_d    = buf_wp_q ^ push;
		buf_rp_d    = buf_rp_q ^ pop;
		buf_mem_d   = buf_mem_q;
		if (push) begin
			buf_mem_d[buf_wp_q] = coll_word_q;
		end
		tbase_d = ins ? ((tbase_q == 32'(TIME_SYNC_CYCLES - 1)) ? 32'h0 : tbase_q + 32'h1)
			: 32'h0;
		tsync_d = ins && (tbase_q == 32'h0) &&
			(gain_q[rscfg_pkg::POS_TIME_ALWAYS] || active_q);
		if (cmd_clear_q) begin
			coll_cnt_d   = 4'h0;
			coll_valid_d = 1'b0;
			buf_cnt_d    = 2'h0;
			buf_wp_d     = 1'b0;
			buf_rp_d     = 1'b0;
			ser_d        = RSCFG_SER_IDLE;
			bit_d        = 4'h0;
			data_d       = 4'h0;
			clk_d        = 1'b0;
			word_idx_d   = 16'h0000;
			frame_num_d  = 16'h0000;
			tbase_d      = 32'h0;
			wpulse_d     = 1'b0;
			fsync_d      = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			filt_q <= 4'h0;
			bypass_q <= 4'h0;
			active_q <= 1'b0;
			tick_q <= 1'b0;
			coll_valid_q <= 1'b0;
			coll_cnt_q <= 4'h0;
			coll_word_q <= '0;
			buf_mem_q[0] <= '0;
			buf_mem_q[1] <= '0;
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
			buf_cnt_q <= 2'h0;
			ser_q <= RSCFG_SER_IDLE;
			sh_q <= '0;
			bit_q <= 4'h0;
			data_q <= 4'h0;
			phase_q <= 1'b0;
			clk_q <= 1'b0;
			word_idx_q <= 16'h0000;
			frame_num_q <= 16'h0000;
			wpulse_q <= 1'b0;
			fsync_q <= 1'b0;
			tsync_q <= 1'b0;
			tbase_q <= 32'h0;
		end else begin
			s1_q <= SAMPLE_IN;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			bypass_q <= bypass_d;
			active_q <= active_d;
			tick_q <= tick_d;
			coll_valid_q <= coll_valid_d;
			coll_cnt_q <= coll_cnt_d;
			coll_word_q <= coll_word_d;
			buf_mem_q <= buf_mem_d;
			buf_wp_q <= buf_wp_d;
			buf_rp_q <= buf_rp_d;
			buf_cnt_q <= buf_cnt_d;
			ser_q <= ser_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			data_q <= data_d;
			phase_q <= phase_d;
			clk_q <= clk_d;
			word_idx_q <= word_idx_d;
			frame_num_q <= frame_num_d;
			wpulse_q <= wpulse_d;
			fsync_q <= fsync_d;
			tsync_q <= tsync_d;
			tbase_q <= tbase_d;
		end
	end

	assign SAMPLE_BYPASS_OUT = bypass_q;
	assign STREAM_DATA_OUT   = data_q;
	assign STREAM_CLK_OUT    = clk_q;
	assign WORD_PULSE_OUT    = wpulse_q;
	assign FRAME_SYNC_OUT    = fsync_q;
	assign TIME_SYNC_OUT     = tsync_q;

endmodule : rscfg_top

// ==== rscfg_top_test.sv ====
// self-checking bench for the stream, gain and clock configuration block
module rscfg_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [7:0] o;} rscfg_row_t;
	logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, v;
	logic [3:0] sample = 4'hA;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] r;
	wire logic awready, wready, bvalid, arready, rvalid, sclk, wpulse, fsync, tsync;
	wire logic ig, qg, ins, band, bufon;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0] byp, sdata;
	wire logic [2:0] div;
	wire logic [15:0] bits, words, pulses, frames, times;
	wire logic [63:0] word;
	wire logic [7:0] outs = {div, band, bufon, ig, qg, ins};
	logic [15:0] b0, f0, p0, t0;
	int fails = 0, cmp_count = 0;
	rscfg_row_t rows [9] = '{
		'{8'h08, 32'h000021C0, 2'h0, 8'h6C}, '{8'h08, 32'h000011C0, 2'h0, 8'h6A},
		'{8'h0C, 32'h01000000, 2'h0, 8'h0A}, '{8'h0C, 32'h30000000, 2'h0, 8'h32},
		'{8'h0C, 32'h41000000, 2'h0, 8'h4A}, '{8'h0C, 32'h90000000, 2'h0, 8'h92},
		'{8'h0C, 32'hE1000000, 2'h0, 8'hEA}, '{8'h0C, 32'h698C0000, 2'h0, 8'h6A},
		'{8'h10, 32'hFFFFFFFF, 2'h2, 8'h6A}};

	always #25 clk = ~clk;

	rscfg_top #(.FRAME_WORDS(2), .TIME_SYNC_CYCLES(16)) dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
		.WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
		.BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
		.ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
		.RREADY_IN(rready), .SAMPLE_IN(sample), .SAMPLE_BYPASS_OUT(byp),
		.STREAM_DATA_OUT(sdata), .STREAM_CLK_OUT(sclk), .WORD_PULSE_OUT(wpulse),
		.FRAME_SYNC_OUT(fsync), .TIME_SYNC_OUT(tsync), .INPHASE_GAIN_ON_OUT(ig),
		.QUAD_GAIN_ON_OUT(qg), .STREAM_INSERT_OUT(ins), .CLOCK_OUT_DIVIDER_OUT(div),
		.OSC_BAND_SELECT_OUT(band), .CLOCK_OUT_BUFFER_ON_OUT(bufon));

	rscfg_sink sink_u (.clk_in(clk), .reset_n_in(rst_n), .stream_clk_in(sclk), .data_in(sdata),
		.word_pulse_in(wpulse), .frame_sync_in(fsync), .time_sync_in(tsync), .bits_out(bits),
		.words_out(words), .pulses_out(pulses), .frames_out(frames), .times_out(times),
		.word_out(word));

	// ==========================================================
	// tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		r = bresp;
		bready <= 1'b0;
		if (n >= 200) fails++;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 200) fails++;
	endtask : rd

	task automatic wait_words(input int k);
		int n;
		logic [15:0] w0;
		w0 = words;
		n = 0;
		while (16'(words - w0) < 16'(k) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) fails++;
	endtask : wait_words

	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	// ==========================================================
	// watchdog
	initial begin
		#(40000 * 50);
		fails++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h08);
		chk(v, rscfg_pkg::RST_STREAM_GAIN);
		rd(8'h0C);
		chk(v, rscfg_pkg::RST_SYNTH_CLOCK);
		rd(8'h20);
		chk(v, 32'h00000000);
		chk(outs, 8'h6C);
		chk({sclk, byp}, 5'h0A);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk(r, rows[i].r);
			rd(rows[i].a);
			chk(v, rows[i].r == 2'h0 ? rows[i].d : 32'h0);
			chk(r, rows[i].r);
			chk(outs, rows[i].o);
		end
		wstrb <= 4'h8;
		wr(8'h0C, 32'h30FFFFFF);
		wstrb <= 4'hF;
		rd(8'h0C);
		chk(v, 32'h308C0000);
		chk(outs, 8'h32);
		$display("test table done");
		wr(8'h08, 32'h00003DF2);
		wait_words(2);
		chk(word, 64'hFFFF0000FFFF0000);
		chk(byp, 4'h0);
		f0 = frames;
		p0 = pulses;
		wait_words(2);
		chk(16'(frames - f0), 16'h1);
		chk(16'(pulses - p0), 16'h2);
		wr(8'h08, 32'h00003DD2);
		wait_words(2);
		chk(word, 64'hFFFF000000000000);
		wr(8'h08, 32'h00003DD3);
		repeat (3) @(posedge clk);
		f0 = frames;
		wait_words(1);
		chk(16'(frames - f0), 16'h1);
		wr(8'h08, 32'h00003DFB);
		repeat (3) @(posedge clk);
		wait_words(3);
		chk(word, 64'h0001000100010001);
		$display("test stream done");
		wr(8'h08, 32'h00003FD2);
		repeat (3) @(posedge clk);
		b0 = bits;
		t0 = times;
		repeat (100) @(posedge clk);
		chk(bits, b0);
		chk(times, t0);
		wr(8'h08, 32'h00003DD6);
		t0 = times;
		repeat (100) @(posedge clk);
		chk(bits, b0);
		chk(16'(times - t0) > 16'h4, 1'b1);
		wr(8'h08, 32'h000039D6);
		wr(8'h08, 32'h00003DD6);
		wait_words(1);
		chk(16'(bits - b0) > 16'h0, 1'b1);
		rd(8'h20);
		chk(v[1:0], 2'h3);
		$display("test stop done");
		sample <= 4'h5;
		wr(8'h08, 32'h000031D6);
		repeat (3) @(posedge clk);
		b0 = bits;
		t0 = times;
		repeat (60) @(posedge clk);
		chk(bits, b0);
		chk(times, t0);
		chk(byp, 4'h5);
		$display("test bypass done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(outs, 8'h6C);
		chk({sclk, wpulse, fsync, tsync, byp}, 8'h00);
		rst_n <= 1'b1;
		rd(8'h08);
		chk(v, rscfg_pkg::RST_STREAM_GAIN);
		$display("test reset again done");
		results();
	end
endmodule : rscfg_top_test
